// *** inc/mli_pkg.sv ***
// Constants, timing counts and state encodings for the multi-axis linear interpolator.
// Summary of operation
// - Selector 0030h picks group 0, 0031h picks group 1; two groups only.
// - Two-axis mode: group 0 drives axes 0/1, group 1 drives axes 2/3.
// - Three-axis mode exists only in group 0 and drives axes 0/1/2.
// - Four-axis mode exists only in group 0 and drives axes 0/1/2/3.
// - Table is 14 words; absolute targets sit at S+6..S+13 in axis order.
// - Acceleration at S, deceleration S+1, target frequency S+2, startup S+4.
// - Per-axis rates and ramps come from the shared profile automatically.
// - Start on an axis busy with a single-axis command flags error, no start.
// - Targets are absolute; start without an established origin flags error.
// - Start from interrupt context during cyclic pulse command flags error.
// - Frequency interval above 100,000,000 flags error and refuses the start.
// - Motion time above 1,000 s flags error and rejects the command.
// - Bad selector, control code or table flags error; otherwise flag clears.
// - Startup above target frequency runs the whole path at target frequency.
// - Each error-free start execution on an idle group begins a new output; issuer pulses start once.
// - Stop halts at once or decelerates, keeping axes on the straight path.
// - Axes busy interpolating refuse single-axis commands until finished.
// - Repeated start on a busy group keeps its target; restart after stops.
// - Abort flag stops motion at once or refuses start, flag left cleared.
// - Rates are recomputed every 8 ms; slow axes need not have 50% duty.
// - Variants without pulse outputs or interpolation treat start as no-op.
package mli_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int PERIOD_MS = 8;
  localparam int PERIOD_CYC = CLK_HZ / 1000 * PERIOD_MS;
  localparam int RAMP_MS = 4;
  localparam int RAMP_MUL = PERIOD_MS / RAMP_MS;
  localparam int DEC_K = 2 * 1000 / RAMP_MS;
  localparam int TIME_MAX_S = 1000;
  localparam logic [27:0] CLK_HZ_W = 28'(CLK_HZ);
  localparam logic [16:0] FREQ_MAX = 17'h1_86A0;
  localparam logic [63:0] RMS_MAX = 64'h0000_0000_05F5_E100;
  localparam logic [15:0] SEL_GRP0 = 16'h0030;
  localparam logic [15:0] SEL_GRP1 = 16'h0031;
  localparam logic [15:0] CODE_2AX = 16'h0002;
  localparam logic [15:0] CODE_3AX = 16'h0003;
  localparam logic [15:0] CODE_4AX = 16'h0004;
  localparam logic [3:0] MASK_2AX = 4'h3;
  localparam logic [3:0] MASK_3AX = 4'h7;
  localparam logic [3:0] MASK_4AX = 4'hF;
  localparam logic [3:0] MASK_G1 = 4'hC;
  localparam int TBL_WORDS = 14;
  localparam int OFS_ACC = 0;
  localparam int OFS_DEC = 1;
  localparam int OFS_FT_LO = 2;
  localparam int OFS_FT_HI = 3;
  localparam int OFS_FS_LO = 4;
  localparam int OFS_FS_HI = 5;
  localparam int OFS_TGT = 6;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_CHECK = 2'b10
  } mli_state_t;
endpackage : mli_pkg

// *** verilog/mli_tbl_mem.sv ***
// Parameter table memory with a registered read port.
`timescale 1ns/1ps
module mli_tbl_mem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_q
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Storage has no reset; software fills the table before any start.
  always_ff @(posedge clk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read data comes one cycle after the address.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_q <= '0;
    end else if (clk_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule : mli_tbl_mem

// *** verilog/mli_path_eng.sv ***
// Path engine: ramped path rate plus per-axis error accumulators for one group.
`timescale 1ns/1ps
module mli_path_eng import mli_pkg::*; #(
  parameter int NAX = 4,
  parameter int PER_CYC = PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic period_tick,
  input wire logic load,
  input wire logic [NAX-1:0][31:0] d_abs,
  input wire logic [31:0] maj_len,
  input wire logic [16:0] acc2,
  input wire logic [16:0] dec2,
  input wire logic [15:0] dec_rate,
  input wire logic [16:0] f_run,
  input wire logic [16:0] f_start,
  input wire logic stop_imm,
  input wire logic stop_dec,
  output logic busy_q,
  output logic [NAX-1:0] step
);
  logic decel_q;
  logic [16:0] f_q, floor_q, frun_q, acc2_q, dec2_q;
  logic [15:0] dec_q;
  logic [27:0] ph_q;
  logic [31:0] rem_q, len_q;
  logic [NAX-1:0][31:0] d_q;
  // Clock cycles per second follow from the recompute period, so a short test period scales time.
  localparam logic [27:0] HZ_W = 28'(PER_CYC / PERIOD_MS * 1000);

  initial begin
    if (PER_CYC / PERIOD_MS * 1000 >= (1 << 28)) $error("PER_CYC too large for phase width");
  end

  // The major axis steps at the path rate; a phase accumulator keeps the rate exact.
  wire [27:0] ph_sum = ph_q + {11'h000, f_q};
  wire maj_tick = busy_q && (ph_sum >= HZ_W);
  // Braking starts once the steps left no longer cover the ramp down.
  wire [63:0] dec_need = 64'(rem_q) * 64'(dec_q) * 64'(DEC_K);
  wire [63:0] f_sq = 64'(f_q) * 64'(f_q);
  wire slow = decel_q || (f_sq >= dec_need);
  wire [17:0] f_up = {1'b0, f_q} + {1'b0, acc2_q};
  wire [17:0] fl_plus = {1'b0, floor_q} + {1'b0, dec2_q};
  wire [16:0] f_dn = ({1'b0, f_q} > fl_plus) ? f_q - dec2_q : floor_q;
  wire [16:0] f_acc = (f_up > {1'b0, frun_q}) ? frun_q : f_up[16:0];
  wire [16:0] f_next = slow ? f_dn : f_acc;
  wire stop_done = period_tick && decel_q && (f_q == floor_q);

  // Path rate, remaining steps and stop handling.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      decel_q <= 1'b0;
      f_q <= '0;
      floor_q <= '0;
      frun_q <= '0;
      acc2_q <= '0;
      dec2_q <= '0;
      dec_q <= '0;
      ph_q <= '0;
      rem_q <= '0;
      len_q <= '0;
      d_q <= '0;
    end else if (clk_en) begin
      if (stop_imm || stop_done) begin
        busy_q <= 1'b0;
      end else if (load) begin
        busy_q <= (maj_len != 32'h0000_0000);
        decel_q <= 1'b0;
        f_q <= f_start;
        floor_q <= f_start;
        frun_q <= f_run;
        acc2_q <= acc2;
        dec2_q <= dec2;
        dec_q <= dec_rate;
        ph_q <= '0;
        rem_q <= maj_len;
        len_q <= maj_len;
        d_q <= d_abs;
      end else if (busy_q) begin
        if (maj_tick) begin
          ph_q <= ph_sum - HZ_W;
          rem_q <= rem_q - 32'h0000_0001;
          busy_q <= (rem_q != 32'h0000_0001);
        end else begin
          ph_q <= ph_sum;
        end
        if (period_tick) begin
          f_q <= f_next;
        end
        if (stop_dec) begin
          decel_q <= 1'b1;
        end
      end
    end
  end

  // Each axis steps on the major ticks where its share of the path is due.
  for (genvar i = 0; i < NAX; i++) begin : g_axis
    logic [32:0] er_q;
    wire [32:0] er_sum = er_q + {1'b0, d_q[i]};
    wire hit = er_sum >= {1'b0, len_q};
    assign step[i] = maj_tick && hit;
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        er_q <= '0;
      end else if (clk_en) begin
        if (load) begin
          er_q <= '0;
        end else if (maj_tick) begin
          er_q <= hit ? er_sum - {1'b0, len_q} : er_sum;
        end
      end
    end
  end
endmodule : mli_path_eng

// *** verilog/mli_top.sv ***
// Multi-axis linear interpolator: command checks, table load, axis ownership and pulses.
`timescale 1ns/1ps
module mli_top import mli_pkg::*; #(
  parameter int PER_CYC = PERIOD_CYC,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic linear_path_start,
  input wire logic [15:0] port_selector,
  input wire logic [15:0] axis_control_code,
  input wire logic [AW-1:0] parameter_table_base,
  input wire logic tbl_wr_en,
  input wire logic [AW-1:0] tbl_wr_addr,
  input wire logic [15:0] tbl_wr_data,
  input wire logic pulse_stop_cmd,
  input wire logic stop_group,
  input wire logic stop_decel,
  input wire logic abort_flag,
  input wire logic irq_context,
  input wire logic cyclic_pulse_active,
  input wire logic [3:0] single_axis_active,
  input wire logic [3:0] origin_established,
  input wire logic transistor_outputs,
  input wire logic interp_supported,
  input wire logic [3:0] single_axis_cmd_req,
  output logic [3:0] single_axis_cmd_refused,
  output logic instruction_error_flag,
  output logic [1:0] group_busy,
  output logic [3:0] axis_busy,
  output logic [3:0] pulse_out,
  output logic [3:0] dir_out
);
  localparam int PW = $clog2(PER_CYC);

  initial begin
    if (PER_CYC < 2) $error("PER_CYC must be at least 2");
    if ((1 << AW) < TBL_WORDS) $error("table memory smaller than one table");
  end

  mli_state_t state_q;
  logic [3:0] idx_q;
  logic [AW-1:0] base_q;
  logic [15:0] sel_q, code_q;
  logic [TBL_WORDS-1:0][15:0] words_q;
  logic err_q;
  logic [PW-1:0] per_q;
  logic [3:0] own0_q, pulse_q, dir_q;
  logic signed [3:0][31:0] pos_q;
  logic [15:0] rd_data;
  logic [3:0] e0_step;
  logic [1:0] e1_step;
  logic e0_busy, e1_busy;

  // Command intake: one execution per cycle of a high start while idle.
  wire variant_ok = transistor_outputs && interp_supported;
  wire start_take = (state_q == ST_IDLE) && linear_path_start && variant_ok;
  wire [AW:0] last_addr = {1'b0, parameter_table_base} + (AW+1)'(TBL_WORDS - 1);
  wire base_bad = last_addr > (AW+1)'((1 << AW) - 1);
  wire [AW-1:0] rd_addr = base_q + AW'(idx_q);
  wire load_done = (state_q == ST_LOAD) && (idx_q == 4'(TBL_WORDS));

  // Table fields at their fixed offsets from the base.
  wire [15:0] acc_w = words_q[OFS_ACC];
  wire [15:0] dec_w = words_q[OFS_DEC];
  wire [31:0] ft_w = {words_q[OFS_FT_HI], words_q[OFS_FT_LO]};
  wire [31:0] fs_w = {words_q[OFS_FS_HI], words_q[OFS_FS_LO]};

  // Selector and control code decoding.
  wire grp1 = (sel_q == SEL_GRP1);
  wire sel_ok = (sel_q == SEL_GRP0) || grp1;
  wire code_ok = (code_q == CODE_2AX) || (!grp1 && (code_q == CODE_3AX || code_q == CODE_4AX));
  wire [3:0] need = grp1 ? MASK_G1 :
                    (code_q == CODE_4AX) ? MASK_4AX :
                    (code_q == CODE_3AX) ? MASK_3AX : MASK_2AX;
  wire tbl_ok = (acc_w != 16'h0000) && (dec_w != 16'h0000) && (ft_w != 32'h0000_0000) &&
                (ft_w <= {15'h0000, FREQ_MAX}) && (fs_w <= {15'h0000, FREQ_MAX});
  wire range_err = !sel_ok || !code_ok || !tbl_ok;

  // Shared profile; a startup above target runs the path at target.
  wire [16:0] ft17 = ft_w[16:0];
  wire [16:0] fs_eff = (fs_w[16:0] > ft17) ? ft17 : fs_w[16:0];
  wire [16:0] f_start = (fs_eff == 17'h0_0000) ? 17'h0_0001 : fs_eff;
  wire [16:0] acc2 = 17'({1'b0, acc_w} * 17'(RAMP_MUL));
  wire [16:0] dec2 = 17'({1'b0, dec_w} * 17'(RAMP_MUL));
  wire [63:0] rms_gap = 64'(ft17) * 64'(ft17) - 64'(fs_eff) * 64'(fs_eff);

  // Absolute targets against present positions give per-axis displacement.
  logic [3:0][31:0] d_abs;
  logic [3:0] d_neg;
  for (genvar i = 0; i < 4; i++) begin : g_delta
    wire signed [31:0] tgt = {words_q[OFS_TGT+2*i+1], words_q[OFS_TGT+2*i]};
    wire signed [32:0] diff = 33'(tgt) - 33'(signed'(pos_q[i]));
    assign d_neg[i] = diff[32];
    assign d_abs[i] = need[i] ? (diff[32] ? 32'(-diff) : diff[31:0]) : 32'h0000_0000;
  end

  // The path length is the largest displacement among the used axes.
  logic [31:0] maj_len;
  always_comb begin
    maj_len = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (d_abs[k] > maj_len) maj_len = d_abs[k];
    end
  end

  // Start-time condition checks.
  wire [3:0] other_axes = grp1 ? (own0_q & {4{e0_busy}}) : (MASK_G1 & {4{e1_busy}});
  wire rep = grp1 ? e1_busy : e0_busy;
  wire busy_err = |(need & (single_axis_active | other_axes));
  wire origin_err = |(need & ~origin_established);
  wire ctx_err = irq_context && cyclic_pulse_active;
  wire rms_err = rms_gap > RMS_MAX;
  wire time_err = 64'(maj_len) > 64'(ft17) * 64'(TIME_MAX_S);
  wire cond_err = busy_err || origin_err || ctx_err || rms_err || time_err;
  wire in_check = (state_q == ST_CHECK);
  wire launch = in_check && !abort_flag && !range_err && !rep && !cond_err;
  wire err_chk = abort_flag ? 1'b0 : range_err ? 1'b1 : rep ? 1'b0 : cond_err;
  wire launch0 = launch && !grp1;
  wire launch1 = launch && grp1;

  // Stop decoding; abort halts both groups at once.
  wire stop0_imm = abort_flag || (pulse_stop_cmd && !stop_group && !stop_decel);
  wire stop1_imm = abort_flag || (pulse_stop_cmd && stop_group && !stop_decel);
  wire stop0_dec = pulse_stop_cmd && !stop_group && stop_decel;
  wire stop1_dec = pulse_stop_cmd && stop_group && stop_decel;
  wire period_tick = (per_q == PW'(PER_CYC - 1));

  // Axis ownership drives busy and refusal of single-axis commands.
  assign group_busy = {e1_busy, e0_busy};
  assign axis_busy = (own0_q & {4{e0_busy}}) | (MASK_G1 & {4{e1_busy}});
  assign single_axis_cmd_refused = single_axis_cmd_req & axis_busy;
  wire [3:0] step_axis = (e0_step & own0_q) | {e1_step, 2'b00};
  assign instruction_error_flag = err_q;
  assign pulse_out = pulse_q;
  assign dir_out = dir_q;

  mli_tbl_mem #(.AW(AW), .DW(16)) u_tbl (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .wr_en(tbl_wr_en),
    .wr_addr(tbl_wr_addr),
    .wr_data(tbl_wr_data),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data)
  );

  mli_path_eng #(.NAX(4), .PER_CYC(PER_CYC)) u_eng0 (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .period_tick(period_tick),
    .load(launch0),
    .d_abs(d_abs),
    .maj_len(maj_len),
    .acc2(acc2),
    .dec2(dec2),
    .dec_rate(dec_w),
    .f_run(ft17),
    .f_start(f_start),
    .stop_imm(stop0_imm),
    .stop_dec(stop0_dec),
    .busy_q(e0_busy),
    .step(e0_step)
  );

  mli_path_eng #(.NAX(2), .PER_CYC(PER_CYC)) u_eng1 (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .period_tick(period_tick),
    .load(launch1),
    .d_abs(d_abs[3:2]),
    .maj_len(maj_len),
    .acc2(acc2),
    .dec2(dec2),
    .dec_rate(dec_w),
    .f_run(ft17),
    .f_start(f_start),
    .stop_imm(stop1_imm),
    .stop_dec(stop1_dec),
    .busy_q(e1_busy),
    .step(e1_step)
  );

  // Command sequencer: capture, table load, then one check cycle.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      idx_q <= '0;
      base_q <= '0;
      sel_q <= '0;
      code_q <= '0;
      err_q <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (start_take && base_bad) begin
            err_q <= 1'b1;
          end else if (start_take) begin
            state_q <= ST_LOAD;
            idx_q <= '0;
            base_q <= parameter_table_base;
            sel_q <= port_selector;
            code_q <= axis_control_code;
          end
        end
        ST_LOAD: begin
          idx_q <= idx_q + 4'h1;
          if (load_done) state_q <= ST_CHECK;
        end
        ST_CHECK: begin
          err_q <= err_chk;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Table words land one cycle behind their read address.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      words_q <= '0;
    end else if (clk_en && state_q == ST_LOAD && idx_q != 4'h0) begin
      words_q[idx_q - 4'h1] <= rd_data;
    end
  end

  // Free-running 8 ms recompute period shared by both groups.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_q <= '0;
    end else if (clk_en) begin
      per_q <= period_tick ? '0 : per_q + PW'(1);
    end
  end

  // Ownership, direction, pulse register and absolute positions.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      own0_q <= '0;
      dir_q <= '0;
      pulse_q <= '0;
      pos_q <= '0;
    end else if (clk_en) begin
      if (launch0) own0_q <= need;
      if (launch) dir_q <= (dir_q & ~need) | (d_neg & need);
      pulse_q <= step_axis;
      for (int k = 0; k < 4; k++) begin
        if (step_axis[k]) pos_q[k] <= dir_q[k] ? pos_q[k] - 32'sd1 : pos_q[k] + 32'sd1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  nop_variant_a: assert property (linear_path_start && !variant_ok && state_q == ST_IDLE && clk_en
    |=> state_q == ST_IDLE && $stable(err_q)) else $error("start ran on unsupported variant");
  abort_halt_a: assert property (abort_flag && clk_en |=> group_busy == 2'b00)
    else $error("abort did not halt motion");
  abort_noerr_a: assert property (in_check && abort_flag && clk_en |=> !err_q && group_busy == 2'b00)
    else $error("abort start left error or motion");
  load_len_a: assert property (start_take && !base_bad && clk_en |=> (state_q == ST_LOAD)[*8])
    else $error("table load shorter than expected");
  range_err_a: assert property (in_check && clk_en && !abort_flag && !sel_ok |=> err_q && !launch)
    else $error("bad selector accepted");
  origin_err_a: assert property (in_check && clk_en && !abort_flag && !range_err && !rep
    && origin_err |=> err_q && $stable(group_busy)) else $error("start without origin");
  ctx_err_a: assert property (in_check && clk_en && !abort_flag && !range_err && !rep && ctx_err
    |=> err_q) else $error("interrupt context start not flagged");
  grp1_axes_a: assert property (e1_busy |-> (axis_busy & MASK_G1) == MASK_G1 && (own0_q & MASK_G1 & {4{e0_busy}}) == 4'h0)
    else $error("group 1 axes overlap group 0");
  refuse_a: assert property (|(single_axis_cmd_req & own0_q) && e0_busy |-> |single_axis_cmd_refused)
    else $error("single-axis command not refused");
  launch_own_a: assert property (launch0 && maj_len != 32'h0 && clk_en && !stop0_imm
    |=> e0_busy && own0_q == $past(need)) else $error("launch did not own axes");
  tick_gap_a: assert property (period_tick && clk_en |=> !period_tick)
    else $error("period tick repeated");

  launch_c: cover property (launch0 ##1 e0_busy);
  decel_c: cover property (e0_busy && stop0_dec ##[1:1000] !e0_busy);
  both_c: cover property (group_busy == 2'b11);
  err_c: cover property (in_check ##1 err_q);
endmodule : mli_top

// *** dv/mli_drv_model.sv ***
// Motor driver model that turns step pulses into signed axis positions.
`timescale 1ns/1ps
module mli_drv_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] step_in,
  input wire logic [3:0] dir_in,
  output int pos [4]
);
  // One step and direction decoder serves every axis alike, so mixed methods cannot occur.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pos <= '{0, 0, 0, 0};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (step_in[i]) pos[i] <= dir_in[i] ? pos[i] - 1 : pos[i] + 1;
      end
    end
  end
endmodule : mli_drv_model

// *** dv/test_multi_axis_linear_interpolator.sv ***
// Self-checking bench for the multi-axis linear interpolator.
`timescale 1ns/1ps
module test_multi_axis_linear_interpolator;
  import mli_pkg::*;
  logic clk, rst_b, st, wen, stp, sgrp, sdec, abrt, irq, cyc, tr, isup, err;
  logic [15:0] ps, cc, wd;
  logic [5:0] wa;
  logic [3:0] saa, origin_search_cmd, req, refd, abusy, pls, dir;
  logic [1:0] gbusy;
  logic [3:0] mk [4] = '{4'h3, 4'h7, 4'hF, 4'hC};
  int pos [4];
  int ex [4];
  int tg [4];
  int fail_count, cmp_count;
  // A short update period keeps each move to a few thousand cycles.
  mli_top #(.PER_CYC(200), .AW(6)) dut_u (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(1'h1),
    .linear_path_start(st),
    .port_selector(ps),
    .axis_control_code(cc),
    .parameter_table_base(6'h00),
    .tbl_wr_en(wen),
    .tbl_wr_addr(wa),
    .tbl_wr_data(wd),
    .pulse_stop_cmd(stp),
    .stop_group(sgrp),
    .stop_decel(sdec),
    .abort_flag(abrt),
    .irq_context(irq),
    .cyclic_pulse_active(cyc),
    .single_axis_active(saa),
    .origin_established(origin_search_cmd),
    .transistor_outputs(tr),
    .interp_supported(isup),
    .single_axis_cmd_req(req),
    .single_axis_cmd_refused(refd),
    .instruction_error_flag(err),
    .group_busy(gbusy),
    .axis_busy(abusy),
    .pulse_out(pls),
    .dir_out(dir)
  );
  mli_drv_model drv_u (.clk(clk), .rst_b(rst_b), .step_in(pls), .dir_in(dir), .pos(pos));
  // Free-running 125 MHz clock.
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // Checking, reporting and access tasks.
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (e !== g) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  task automatic wr(logic [5:0] a, logic [15:0] d);
    @(posedge clk);
    #1;
    wen = 1'h1;
    wa = a;
    wd = d;
    @(posedge clk);
    #1;
    wen = 1'h0;
  endtask : wr
  task automatic wr32(logic [5:0] a, logic [31:0] v);
    wr(a, v[15:0]);
    wr(a + 6'h01, v[31:16]);
  endtask : wr32
  task automatic tbl(logic [31:0] ft, logic [31:0] fs);
    wr(6'h00, 16'h0032);
    wr(6'h01, 16'h0032);
    wr32(6'h02, ft);
    wr32(6'h04, fs);
    foreach (tg[i]) wr32(6'(6 + 2 * i), tg[i]);
  endtask : tbl
  // The result lands on the sixteenth edge after the taking edge.
  task automatic go(logic [15:0] s, logic [15:0] c);
    @(posedge clk);
    #1;
    st = 1'h1;
    ps = s;
    cc = c;
    @(posedge clk);
    #1;
    st = 1'h0;
    repeat (17) @(posedge clk);
    #1;
  endtask : go
  task automatic idle();
    int n = 0;
    while (gbusy !== 2'h0 && n < 40000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 40000) begin
      fail_count++;
      end_sim();
    end
    repeat (4) @(posedge clk);
    #1;
  endtask : idle
  // Main sequence.
  initial begin
    int d;
    {st, wen, stp, sgrp, sdec, abrt, irq, cyc, saa, origin_search_cmd, req, wa, wd, ps, cc} = '0;
    {tr, isup} = 2'h3;
    {fail_count, cmp_count} = '0;
    ex = '{0, 0, 0, 0};
    rst_b = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    rst_b = 1'h1;
    tg = '{10, -5, 4, -3};
    tbl(32'h0000_03E8, 32'h0000_0064);
    go(SEL_GRP0, CODE_2AX);
    chk("no origin", 1'h1, err);
    origin_search_cmd = 4'hF;
    go(16'h0032, CODE_2AX);
    chk("bad port", 1'h1, err);
    go(SEL_GRP1, CODE_3AX);
    chk("3ax grp1", 1'h1, err);
    go(SEL_GRP1, CODE_4AX);
    chk("4ax grp1", 1'h1, err);
    go(SEL_GRP0, 16'h0005);
    chk("bad code", 1'h1, err);
    {irq, cyc} = 2'h3;
    go(SEL_GRP0, CODE_2AX);
    chk("irq ctx", 1'h1, err);
    {irq, cyc} = 2'h0;
    saa = 4'h2;
    go(SEL_GRP0, CODE_2AX);
    chk("axis busy", 1'h1, err);
    saa = 4'h0;
    tr = 1'h0;
    go(SEL_GRP0, CODE_2AX);
    chk("no-op flag", 1'h1, err);
    chk("no-op busy", 2'h0, gbusy);
    tr = 1'h1;
    abrt = 1'h1;
    go(SEL_GRP0, CODE_2AX);
    chk("abort flag", 1'h0, err);
    chk("abort busy", 2'h0, gbusy);
    abrt = 1'h0;
    $display("test refusals done");
    // Every mode moves exactly its own axes to the absolute targets.
    for (int k = 0; k < 4; k++) begin
      foreach (tg[i]) tg[i] = (k[0] ? -1 : 1) * (3 * (i % 2) + k + 2);
      tbl(32'h0000_03E8, 32'h0000_0064);
      go(k < 3 ? SEL_GRP0 : SEL_GRP1, k < 3 ? 16'(k + 2) : CODE_2AX);
      chk("start flag", 1'h0, err);
      chk("axes", mk[k], abusy);
      req = 4'hF;
      #1;
      chk("refused", mk[k], refd);
      req = 4'h0;
      if (k == 0) begin
        wr32(6'h06, 32'h0000_0063);
        go(SEL_GRP0, CODE_2AX);
        chk("repeat flag", 1'h0, err);
      end
      idle();
      foreach (tg[i]) if (mk[k][i]) ex[i] = tg[i];
      foreach (ex[i]) chk("position", ex[i], pos[i]);
    end
    $display("test modes done");
    // A decelerating stop keeps the 2:1 ratio of the two displacements.
    tg = '{ex[0] + 2000, ex[1] + 1000, ex[2], ex[3]};
    tbl(32'h0000_03E8, 32'h0000_0064);
    go(SEL_GRP0, CODE_2AX);
    repeat (3000) @(posedge clk);
    #1;
    {stp, sgrp, sdec} = 3'h5;
    @(posedge clk);
    #1;
    stp = 1'h0;
    idle();
    d = (pos[0] - ex[0]) - 2 * (pos[1] - ex[1]);
    chk("on path", 1'h1, d <= 2 && d >= -2);
    go(SEL_GRP0, CODE_2AX);
    chk("restart", 2'h1, gbusy);
    repeat (500) @(posedge clk);
    #1;
    {stp, sdec} = 2'h2;
    @(posedge clk);
    #1;
    stp = 1'h0;
    @(posedge clk);
    #1;
    chk("halt", 2'h0, gbusy);
    repeat (600) @(posedge clk);
    #1;
    chk("no resume", 2'h0, gbusy);
    $display("test stops done");
    // Profile limits: a wide frequency interval and an overlong move.
    foreach (ex[i]) ex[i] = pos[i];
    tbl(32'h0001_86A0, 32'h0000_0001);
    go(SEL_GRP0, CODE_2AX);
    chk("rms", 1'h1, err);
    tbl(32'h0000_0001, 32'h0000_0000);
    go(SEL_GRP0, CODE_2AX);
    chk("time", 1'h1, err);
    chk("time busy", 2'h0, gbusy);
    foreach (ex[i]) chk("still", ex[i], pos[i]);
    $display("test limits done");
    end_sim();
  end
endmodule : test_multi_axis_linear_interpolator
